// file: hw/ref_mon_regs.vh
// register map, field positions, reset values and timing for ref_mon
// assumes a 10 MHz pclk and 32-bit APB byte addressing
`ifndef REF_MON_REGS_VH
`define REF_MON_REGS_VH

`define CLK_KHZ 10000
`define PERIOD_MS 128

`define A_CTRL 12'h000
`define A_INT_STS 12'h004
`define A_VALID 12'h008
`define A_REVAL 12'h00c
`define A_SEL 12'h010
`define A_FLIM 12'h014
`define A_LOCK 12'h018
`define A_FAST 12'h01c
`define A_GAP 12'h020
`define A_ACT_ALM 12'h024
`define A_SOFT_ALM 12'h028
`define A_HARD_ALM 12'h02c
`define A_BCFG 12'h040
`define A_CHCFG 12'h080

`define B_REVERT 0
`define B_PHLOST_EN 1
`define B_MIRROR_EN 2
`define B_REF_FAIL 6

`define CTRL_RST 3'h1
`define SOFT_RST 10'h05a
`define HARD_RST 10'h078
`define LOCK_RST 10'h048
`define FAST_RST 16'h09c4
`define GAP_RST 16'h0fa0
`define SIZE_RST 4'h8
`define SET_RST 4'h6
`define CLR_RST 4'h4
`define DECAY_RST 2'h1

`endif

// file: hw/ref_mon.v
// reference clock activity/frequency monitor and priority selector
// assumes ref_clk_in pins are asynchronous; freq_mag_in and phase_fault_in
// come from the loop logic on pclk; APB slave, zero wait states
// Behaviour
// [R1] ~two missing selected cycles freeze loop in holdover
// [R2] loss flag readable; optional phase-lost indication
// [R3] recovery before rejection resumes nearest-edge locking
// [R4] per-channel bucket picks one of four configs
// [R5] add one per irregular 128 ms period
// [R6] bucket saturates at programmed capacity
// [R7] fill 8/s, leak 8/s down to 1/s
// [R8] fill in a period suppresses that leak
// [R9] alarm and reject at set threshold
// [R10] alarm holds until at or below clear threshold
// [R11] empty bucket alarms after set/8 seconds
// [R12] clear time 2^decay*(size-clear)/8 seconds
// [R13] unselected rejected for inactivity or out-of-band
// [R14] selected also rejected for phase, lock range
// [R15] bucket-based loss takes at least one 128 ms period
// [R16] mirror loss flag on test output pin
// [R17] software clears loss flag by status write
// [R18] soft/hard frequency limits, programmable
// [R19] lock range limit programmable, default 9.2 ppm
// [R20] select highest priority valid source
// [R21] revertive: switch to better revalidated source
// [R22] non-revertive: keep, flag revalidation
// [R23] priority 1..15, lower preferred, zero excluded
// [R24] failure of selected always switches
// [R25] single clock, counters derive all timing
`include "ref_mon_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module ref_mon #(
	parameter N = 14,
	parameter PERIOD_CYC = `PERIOD_MS * `CLK_KHZ
) (
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// references and loop status
	input wire [N-1:0] ref_clk_in,
	input wire [N*10-1:0] freq_mag_in,
	input wire phase_fault_in,
	// to loop
	output reg [3:0] sel_chan,
	output reg sel_ok,
	output reg holdover,
	output reg phase_lost,
	output reg resume_lock,
	// test data mirror
	output reg tdo_mirror,
	output reg tdo_mirror_en
);

	// magnitude above limit; one step is 0.127 ppm
	function lim_exc;
		input [9:0] mag;
		input [9:0] lim;
		begin
			lim_exc = (mag > lim);
		end
	endfunction

	// leak due once every 2^decay periods
	function leak_due;
		input [1:0] decay;
		input [2:0] pcnt;
		reg [2:0] m;
		begin
			m = (3'h1 << decay) - 3'h1;
			leak_due = ((pcnt & m) == m);
		end
	endfunction

	// one loop variable per process, so none has two drivers
	integer i;
	integer f;
	integer c;
	integer j;
	integer k;

	reg [N-1:0] s1_q;
	reg [N-1:0] s2_q;
	reg [N-1:0] s3_q;
	reg [15:0] idle_q [0:N-1];
	reg [N-1:0] irr_q;
	reg [3:0] acc_q [0:N-1];
	reg [N-1:0] act_alm_q;
	reg [N-1:0] soft_q;
	reg [N-1:0] hard_q;
	reg [N-1:0] lock_exc_q;
	reg [N-1:0] valid_q;
	reg [N-1:0] reval_q;
	reg [15:0] bcfg_q [0:3];
	reg [5:0] chcfg_q [0:N-1];
	reg [2:0] ctrl_q;
	reg [9:0] soft_lim_q;
	reg [9:0] hard_lim_q;
	reg [9:0] lock_lim_q;
	reg [15:0] fast_lim_q;
	reg [15:0] gap_lim_q;
	reg ref_fail_q;
	reg [20:0] per_q;
	reg tick_q;
	reg [2:0] pcnt_q;
	reg miss_q;
	// per-channel view of the shared bucket configurations
	reg [3:0] size_c [0:N-1];
	reg [3:0] set_c [0:N-1];
	reg [3:0] clr_c [0:N-1];
	reg [1:0] decay_c [0:N-1];

	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite & pready;
	wire [N-1:0] edge_seen = s2_q & ~s3_q;
	wire [N-1:0] valid_d = ~act_alm_q & ~hard_q;
	wire [3:0] sel_pr = chcfg_q[sel_chan][3:0];
	wire sel_good = sel_ok & valid_q[sel_chan] & ~phase_fault_in
		& ~lock_exc_q[sel_chan] & (sel_pr != 4'h0); // [R14]
	wire fast_miss = sel_ok & (idle_q[sel_chan] >= fast_lim_q); // [R1]
	wire bsel = (paddr[11:4] == 8'h04);
	wire csel = (paddr[11:6] == 6'h02) && (paddr[5:2] < N);
	wire wr_sts = wr && (paddr == `A_INT_STS);
	wire wr_reval = wr && (paddr == `A_REVAL);

	reg best_ok;
	reg [3:0] best_idx;
	reg [3:0] best_pr;
	reg [31:0] rd_d;
	reg err_d;
	reg [3:0] pr;

	// period tick and period count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_q <= 21'h0;
			tick_q <= 1'b0;
			pcnt_q <= 3'h0;
		end else begin
			tick_q <= (per_q == PERIOD_CYC - 1); // [R25] [R5]
			if (per_q == PERIOD_CYC - 1)
				per_q <= 21'h0;
			else
				per_q <= per_q + 21'h1;
			if (tick_q)
				pcnt_q <= pcnt_q + 3'h1;
		end
	end

	// shared configurations fanned out, one copy per channel
	always @* begin
		for (c = 0; c < N; c = c + 1) begin
			size_c[c] = bcfg_q[chcfg_q[c][5:4]][3:0]; // [R4]
			set_c[c] = bcfg_q[chcfg_q[c][5:4]][7:4];
			decay_c[c] = bcfg_q[chcfg_q[c][5:4]][9:8];
			clr_c[c] = bcfg_q[chcfg_q[c][5:4]][15:12];
		end
	end

	// frequency band checks against the programmed limits
	// registered so the selector sees one settled verdict per cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_q <= {N{1'b0}};
			hard_q <= {N{1'b0}};
			lock_exc_q <= {N{1'b0}};
		end else begin
			for (f = 0; f < N; f = f + 1) begin
				soft_q[f] <= lim_exc(freq_mag_in[f*10 +: 10],
					soft_lim_q); // [R18]
				hard_q[f] <= lim_exc(freq_mag_in[f*10 +: 10],
					hard_lim_q); // [R18]
				lock_exc_q[f] <= lim_exc(freq_mag_in[f*10 +: 10],
					lock_lim_q); // [R19]
			end
		end
	end

	// synchronisers, idle counters, buckets, alarms
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= {N{1'b0}};
			s2_q <= {N{1'b0}};
			s3_q <= {N{1'b0}};
			irr_q <= {N{1'b0}};
			act_alm_q <= {N{1'b0}};
			valid_q <= {N{1'b0}};
			for (i = 0; i < N; i = i + 1) begin
				idle_q[i] <= 16'h0;
				acc_q[i] <= 4'h0;
			end
		end else begin
			s1_q <= ref_clk_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			valid_q <= valid_d; // [R13]
			for (i = 0; i < N; i = i + 1) begin
				// idle count saturates so a dead pin never wraps to zero
				if (edge_seen[i])
					idle_q[i] <= 16'h0;
				else if (idle_q[i] != 16'hffff)
					idle_q[i] <= idle_q[i] + 16'h1;
				// irregular if a gap overruns the jitter allowance
				if (tick_q)
					irr_q[i] <= 1'b0;
				else if (idle_q[i] >= gap_lim_q)
					irr_q[i] <= 1'b1; // [R5]
				if (tick_q) begin
					if (irr_q[i]) begin
						if (acc_q[i] < size_c[i])
							acc_q[i] <= acc_q[i] + 4'h1; // [R5] [R6] [R7]
					end else if (leak_due(decay_c[i], pcnt_q) &&
						acc_q[i] != 4'h0)
						acc_q[i] <= acc_q[i] - 4'h1; // [R7] [R8]
				end
				// reaching set alarms, so set/8 s from empty
				// a zero set threshold never alarms
				if (acc_q[i] >= set_c[i] && set_c[i] != 4'h0)
					act_alm_q[i] <= 1'b1; // [R9] [R11] [R15]
				else if (acc_q[i] <= clr_c[i])
					act_alm_q[i] <= 1'b0; // [R10] [R12]
			end
		end
	end

	// best valid source: lowest nonzero priority, lowest channel on ties
	always @* begin
		best_ok = 1'b0;
		best_idx = 4'h0;
		best_pr = 4'hf;
		pr = 4'h0;
		for (j = 0; j < N; j = j + 1) begin
			pr = chcfg_q[j][3:0];
			// a phase fault belongs to the source the loop follows,
			// so that source alone drops out of the race
			if (valid_q[j] && pr != 4'h0 && !lock_exc_q[j] &&
				!(phase_fault_in && sel_ok && sel_chan == j[3:0]) &&
				(!best_ok || pr < best_pr)) begin // [R20] [R23] [R14]
				best_ok = 1'b1;
				best_idx = j[3:0];
				best_pr = pr;
			end
		end
	end

	// selection and fast loss handling
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_chan <= 4'h0;
			sel_ok <= 1'b0;
			holdover <= 1'b1;
			miss_q <= 1'b0;
			resume_lock <= 1'b0;
			phase_lost <= 1'b0;
			tdo_mirror <= 1'b0;
			tdo_mirror_en <= 1'b0;
		end else begin
			if (!sel_good) begin
				sel_ok <= best_ok; // [R14] [R24]
				sel_chan <= best_idx;
			end else if (ctrl_q[`B_REVERT] && best_ok &&
				best_pr < sel_pr) begin
				sel_chan <= best_idx; // [R21]
			end
			// non-revertive keeps the current source here [R22]
			miss_q <= fast_miss;
			holdover <= fast_miss | ~sel_good; // [R1]
			// back before rejection: pick up nearest edge, no slip
			resume_lock <= miss_q & ~fast_miss & sel_good; // [R3]
			phase_lost <= fast_miss & ctrl_q[`B_PHLOST_EN]; // [R2]
			tdo_mirror_en <= ctrl_q[`B_MIRROR_EN];
			tdo_mirror <= ctrl_q[`B_MIRROR_EN] & ref_fail_q; // [R16]
		end
	end

	// read mux, built in the setup cycle
	always @* begin
		rd_d = 32'h0;
		err_d = 1'b0;
		if (bsel)
			rd_d = {16'h0, bcfg_q[paddr[3:2]]};
		else if (csel)
			rd_d = {26'h0, chcfg_q[paddr[5:2]]};
		else begin
			case (paddr)
			`A_CTRL: rd_d = {29'h0, ctrl_q};
			`A_INT_STS: rd_d = {25'h0, ref_fail_q, 6'h0}; // [R2]
			`A_VALID: rd_d = {{(32-N){1'b0}}, valid_q};
			`A_REVAL: rd_d = {{(32-N){1'b0}}, reval_q};
			`A_SEL: rd_d = {26'h0, holdover, sel_ok, sel_chan};
			`A_FLIM: rd_d = {6'h0, hard_lim_q, 6'h0, soft_lim_q};
			`A_LOCK: rd_d = {22'h0, lock_lim_q};
			`A_FAST: rd_d = {16'h0, fast_lim_q};
			`A_GAP: rd_d = {16'h0, gap_lim_q};
			`A_ACT_ALM: rd_d = {{(32-N){1'b0}}, act_alm_q};
			`A_SOFT_ALM: rd_d = {{(32-N){1'b0}}, soft_q};
			`A_HARD_ALM: rd_d = {{(32-N){1'b0}}, hard_q};
			default: err_d = 1'b1;
			endcase
		end
	end

	// apb slave and writable registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ctrl_q <= `CTRL_RST;
			soft_lim_q <= `SOFT_RST;
			hard_lim_q <= `HARD_RST;
			lock_lim_q <= `LOCK_RST;
			fast_lim_q <= `FAST_RST;
			gap_lim_q <= `GAP_RST;
			ref_fail_q <= 1'b0;
			reval_q <= {N{1'b0}};
			for (k = 0; k < 4; k = k + 1)
				bcfg_q[k] <= {`CLR_RST, 2'h0, `DECAY_RST,
					`SET_RST, `SIZE_RST};
			// channel k starts at priority k+1, configuration 0
			for (k = 0; k < N; k = k + 1)
				chcfg_q[k] <= {2'h0, k[3:0] + 4'h1};
		end else begin
			pready <= setup;
			// error answer stands only with pready, never beyond
			pslverr <= setup & err_d;
			if (setup) begin
				prdata <= rd_d;
			end
			if (wr && bsel)
				bcfg_q[paddr[3:2]] <= pwdata[15:0];
			if (wr && csel)
				chcfg_q[paddr[5:2]] <= pwdata[5:0];
			if (wr) begin
				case (paddr)
				`A_CTRL: ctrl_q <= pwdata[2:0];
				`A_FLIM: begin
					soft_lim_q <= pwdata[9:0]; // [R18]
					hard_lim_q <= pwdata[25:16];
				end
				`A_LOCK: lock_lim_q <= pwdata[9:0]; // [R19]
				`A_FAST: fast_lim_q <= pwdata[15:0];
				`A_GAP: gap_lim_q <= pwdata[15:0];
				default: ;
				endcase
			end
			// set beats write-one-to-clear
			if (fast_miss)
				ref_fail_q <= 1'b1; // [R1] [R2]
			else if (wr_sts && pwdata[`B_REF_FAIL])
				ref_fail_q <= 1'b0; // [R17]
			// first validation after reset counts as newly validated
			for (k = 0; k < N; k = k + 1) begin
				if (valid_d[k] & ~valid_q[k])
					reval_q[k] <= 1'b1; // [R22]
				else if (wr_reval && pwdata[k])
					reval_q[k] <= 1'b0;
			end
		end
	end

endmodule // ref_mon

`default_nettype wire

// file: tb/ref_mon_sva.sv
// checker: apb handshake and loop-facing output relations of ref_mon
// assumes one pclk domain, presetn asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module ref_mon_sva (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// loop side
	input wire logic sel_ok,
	input wire logic holdover,
	input wire logic phase_lost,
	input wire logic resume_lock,
	input wire logic tdo_mirror,
	input wire logic tdo_mirror_en
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	chk_lost_holds: assert property (phase_lost |-> holdover)
		else $error("phase lost without holdover");
	chk_mirror_gate: assert property (tdo_mirror |-> tdo_mirror_en)
		else $error("mirror while disabled");
	chk_idle_holds: assert property (!sel_ok |-> holdover)
		else $error("no source yet loop free");
	chk_resume_pulse: assert property (resume_lock |=> !resume_lock)
		else $error("relock pulse too long");
	chk_resume_sel: assert property (resume_lock |-> sel_ok)
		else $error("relock with no source");
	chk_resume_free: assert property (resume_lock |-> !holdover)
		else $error("relock while loop frozen");
endmodule // ref_mon_sva
bind ref_mon ref_mon_sva u_sva (.*);
`default_nettype wire

// file: tb/ref_src_model.sv
// reference clock sources, one per channel
// assumes run[i] low means a dead source whose pin stays stuck
`timescale 1ns/1ps
`default_nettype none
module ref_src_model #(
	parameter N = 14,
	parameter HALF = 310
) (
	// control
	input wire logic [N-1:0] run,
	// pins
	output var logic [N-1:0] ref_clk
);
	// half period off the pclk grid so edges drift against it
	initial begin
		ref_clk = '0;
		forever #(HALF) ref_clk = ref_clk ^ run;
	end
endmodule // ref_src_model
`default_nettype wire

// file: tb/tb_ref_mon.sv
// testbench for ref_mon: defaults, fast loss, bucket timing, selection
// assumes ref_src_model drives the reference pins
`include "ref_mon_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_ref_mon;
	// short tick so bucket timing fits a short run
	localparam int P = 64;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, phase_fault_in = 1'h0, e;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, r;
	logic [139:0] freq_mag_in = '0;
	logic [13:0] run = 14'h3fff;
	logic [44:0] rows [8];
	wire [31:0] prdata;
	wire [13:0] ref_clk_in;
	wire [3:0] sel_chan;
	wire pready, pslverr, sel_ok, holdover, phase_lost, resume_lock;
	wire tdo_mirror, tdo_mirror_en;
	wire [1:0] flags = {resume_lock, holdover};
	int mismatches = 0, checked = 0, n, k;
	ref_mon #(.PERIOD_CYC(P)) dut (.*);
	ref_src_model src (.run(run), .ref_clk(ref_clk_in));
	initial begin
		forever #50 pclk = ~pclk;
	end
	task complete_run();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task timeout();
		chk(32'h0, 32'h1);
		complete_run();
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'h1 && i < 20);
		if (i >= 20)
			timeout();
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(r, x);
	endtask
	task wsel(input logic [3:0] c, input int lim);
		n = 0;
		while (sel_chan !== c && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk({28'h0, sel_chan}, {28'h0, c});
		if (n >= lim)
			complete_run();
	endtask
	task wbit(input int b, input int lim);
		k = 0;
		while (flags[b] !== 1'h1 && k < lim) begin
			@(posedge pclk);
			k++;
		end
		if (k >= lim)
			timeout();
	endtask
	initial begin
		rows = '{{1'h0, `A_CTRL, 32'h1}, {1'h0, `A_FLIM, 32'h78005a},
			{1'h0, `A_LOCK, 32'h48}, {1'h0, `A_FAST, 32'h9c4},
			{1'h0, `A_GAP, 32'hfa0}, {1'h0, 12'h04c, 32'h4168},
			{1'h0, 12'h0b4, 32'he}, {1'h1, 12'h030, 32'h0}};
		repeat (4) @(posedge pclk);
		chk({31'h0, holdover}, 32'h1);
		presetn <= 1'h1;
		foreach (rows[j]) begin
			rd(rows[j][43:32], rows[j][31:0]);
			chk({31'h0, e}, {31'h0, rows[j][44]});
		end
		apb(1'h1, `A_FAST, 32'h14);
		apb(1'h1, `A_GAP, 32'h1e);
		apb(1'h1, `A_CTRL, 32'h6);
		wsel(4'h0, 8 * P);
		rd(`A_SEL, 32'h10);
		chk({31'h0, sel_ok}, 32'h1);
		rd(`A_CTRL, 32'h6);
		chk({31'h0, tdo_mirror_en}, 32'h1);
		chk({31'h0, holdover}, 32'h0);
		run[0] <= 1'h0;
		wbit(0, 40);
		rd(`A_INT_STS, 32'h40);
		chk({30'h0, phase_lost, tdo_mirror}, 32'h3);
		run[0] <= 1'h1;
		wbit(1, 40);
		apb(1'h1, `A_INT_STS, 32'h40);
		rd(`A_INT_STS, 32'h0);
		chk({31'h0, tdo_mirror}, 32'h0);
		run[0] <= 1'h0;
		wsel(4'h1, 10 * P);
		chk({31'h0, n > 3 * P}, 32'h1);
		rd(`A_ACT_ALM, 32'h1);
		chk({31'h0, holdover}, 32'h0);
		// long enough stopped for the bucket to pin at its size
		repeat (6 * P) @(posedge pclk);
		// flags left from the first validation would end the wait at once
		apb(1'h1, `A_REVAL, 32'h3fff);
		run[0] <= 1'h1;
		k = 0;
		do begin
			repeat (P) @(posedge pclk);
			apb(1'h0, `A_REVAL, 32'h0);
			k++;
		end while (r[0] !== 1'h1 && k < 20);
		chk({31'h0, k inside {[6:10]}}, 32'h1);
		chk({28'h0, sel_chan}, 32'h1);
		apb(1'h1, `A_CTRL, 32'h7);
		wsel(4'h0, 50);
		apb(1'h1, 12'h080, 32'h0);
		wsel(4'h1, 50);
		apb(1'h1, 12'h080, 32'h1);
		wsel(4'h0, 50);
		freq_mag_in[9:0] <= 10'h079;
		wsel(4'h1, 3 * P);
		rd(`A_HARD_ALM, 32'h1);
		rd(`A_SOFT_ALM, 32'h1);
		// phase fault drops the followed source, revertive brings it back
		phase_fault_in <= 1'h1;
		wsel(4'h2, 10);
		phase_fault_in <= 1'h0;
		wsel(4'h1, 10);
		complete_run();
	end
endmodule // tb_ref_mon
`default_nettype wire
